/* flash_pin_pkg.sv */
package flash_pin_pkg;

  // Lane widths of the serial link
  typedef enum logic [1:0] {
    LANES_1 = 2'b00,
    LANES_2 = 2'b01,
    LANES_4 = 2'b10
  } lane_mode_t;

  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 24;
  localparam int ADDR_BYTES  = 3;
  localparam int SECTOR_LSB  = 12;
  localparam int HALF_LSB    = 15;
  localparam int BLOCK_LSB   = 16;
  localparam int SYNC_STAGES = 3;
  localparam int BUF_DEPTH   = 2;

  localparam logic [7:0] TX_IDLE_BYTE = 8'hFF;
  localparam logic [3:0] OE_OFF       = 4'h0;
  localparam logic [1:0] IDX_RST      = 2'h0;
  localparam logic [2:0] BIT_RST      = 3'h0;

  // A received byte and its position within the selection
  typedef struct packed {
    logic [7:0] data;
    logic [1:0] index;
  } rx_word_t;

  // Decoded location of the captured byte address
  typedef struct packed {
    logic [23:0] addr;
    logic [11:0] sector;
    logic [8:0]  half_block;
    logic [7:0]  block;
  } addr_info_t;

endpackage : flash_pin_pkg

/* rx_word_buffer.sv */
`timescale 1ns/10ps
`default_nettype none
module rx_word_buffer #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  // Clocking
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  if (DEPTH < 2 || DEPTH > 8 || WIDTH < 1) begin : g_bad_param
    $error("rx_word_buffer: unsupported WIDTH or DEPTH");
  end

  // Shift organisation keeps the head in entry 0, so the drain side
  // reads straight out of a flip-flop.
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [3:0]       cnt_r;
  logic             push;
  logic             pop;

  assign in_ready = (cnt_r < 4'(DEPTH));
  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem_r[0];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_r     <= 4'h0;
      out_valid <= 1'b0;
    end else if (ce) begin
      if (push && !pop) begin
        cnt_r     <= cnt_r + 4'h1;
        out_valid <= 1'b1;
      end else if (pop && !push) begin
        cnt_r     <= cnt_r - 4'h1;
        out_valid <= (cnt_r > 4'h1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (pop) begin
          if (push && (4'(i) == cnt_r - 4'h1)) begin
            mem_r[i] <= in_data;
          end else if (i < DEPTH - 1) begin
            mem_r[i] <= mem_r[i+1];
          end
        end else if (push && (4'(i) == cnt_r)) begin
          mem_r[i] <= in_data;
        end
      end
    end
  end
endmodule : rx_word_buffer
`default_nettype wire

/* serial_flash_pin_frontend.sv */
// How it works
// - Chip select high: ignore all pins but the protect pin, all data line enables off.
// - Deselected and not busy gives standby; chip select low gives active.
// - No decoding until a chip select falling edge follows reset.
// - Command, address and write data sampled on clock rising edges.
// - Output bits change only after clock falling edges.
// - Single-lane mode: line 0 is input only, one bit per clock.
// - Dual/quad: line 0 sampled on rises, driven from falls when returning.
// - Dual/quad: line 1 receives on rises, shifts read data on falls.
// - Quad off, protect hi 0, lo 1, protect pin low blocks status writes.
// - Quad on: protect pin is data line 2, no write protection.
// - Quad off: fourth pin is the pause input.
// - Quad on: fourth pin is data line 3, never pauses.
// - Pause freezes bit and byte position, only while selected.
// - Pause starts on pause-pin fall while clock is low.
// - Pause ends on pause-pin rise while clock is low, then resumes.
// - Address splits into 4 KB sectors, 32 KB half blocks, 64 KB blocks.
// - While paused, outputs off, data input and clock ignored.
// - Deselect while paused resets interface and drops the command.
// - Quad width honoured only while quad enable is set.
`timescale 1ns/10ps
`default_nettype none
module serial_flash_pin_frontend (
  // Clocking
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  // Link pins
  input  wire logic                       cs_n_pin,
  input  wire logic                       sck_pin,
  input  wire logic [3:0]                 data_line_in,
  output logic [3:0]                      data_line_out,
  output logic [3:0]                      data_line_oe,
  // Mode and status bits from the core
  input  wire logic                       quad_io_enable_bit,
  input  wire logic                       status_protect_bit_hi,
  input  wire logic                       status_protect_bit_lo,
  input  wire logic                       internal_busy,
  input  wire flash_pin_pkg::lane_mode_t  lane_mode,
  input  wire logic                       return_data,
  // Received bytes
  output logic                            rx_valid,
  input  wire logic                       rx_ready,
  output flash_pin_pkg::rx_word_t         rx_word,
  // Bytes to return
  input  wire logic                       tx_valid,
  output logic                            tx_take_r,
  input  wire logic [7:0]                 tx_data,
  // State
  output logic                            standby_r,
  output logic                            active_r,
  output logic                            paused_r,
  output logic                            status_write_blocked_r,
  output logic                            rx_overrun_r,
  output logic                            addr_valid_r,
  output flash_pin_pkg::addr_info_t       addr_info_r
);
  localparam int NS = flash_pin_pkg::SYNC_STAGES;

  // Pin synchronisers: a change counts once the last two stages agree
  logic [NS-1:0] cs_s_r;
  logic [NS-1:0] sck_s_r;
  logic [NS-1:0] dl_s_r [4];
  logic          cs_f_r;
  logic          sck_f_r;
  logic [3:0]    dl_f_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cs_s_r  <= '1;
      sck_s_r <= '0;
      for (int i = 0; i < 4; i++) begin
        dl_s_r[i] <= '1;
      end
    end else if (ce) begin
      cs_s_r  <= {cs_s_r[NS-2:0], cs_n_pin};
      sck_s_r <= {sck_s_r[NS-2:0], sck_pin};
      for (int i = 0; i < 4; i++) begin
        dl_s_r[i] <= {dl_s_r[i][NS-2:0], data_line_in[i]};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cs_f_r  <= 1'b1;
      sck_f_r <= 1'b0;
      dl_f_r  <= 4'hF;
    end else if (ce) begin
      if (cs_s_r[1] == cs_s_r[2]) begin
        cs_f_r <= cs_s_r[2];
      end
      if (sck_s_r[1] == sck_s_r[2]) begin
        sck_f_r <= sck_s_r[2];
      end
      for (int i = 0; i < 4; i++) begin
        if (dl_s_r[i][1] == dl_s_r[i][2]) begin
          dl_f_r[i] <= dl_s_r[i][2];
        end
      end
    end
  end

  // Edge detection on the filtered levels
  logic cs_d_r;
  logic sck_d_r;
  logic hold_d_r;
  logic hold_lvl;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cs_d_r   <= 1'b1;
      sck_d_r  <= 1'b0;
      hold_d_r <= 1'b1;
    end else if (ce) begin
      cs_d_r   <= cs_f_r;
      sck_d_r  <= sck_f_r;
      hold_d_r <= hold_lvl;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic hold_fall;
  logic hold_rise;
  // Delayed levels reset to the idle pin levels, so no false edge
  // follows reset.
  assign cs_fall   = cs_d_r && !cs_f_r;
  assign cs_rise   = !cs_d_r && cs_f_r;
  assign sck_rise  = !sck_d_r && sck_f_r;
  assign sck_fall  = sck_d_r && !sck_f_r;
  assign hold_lvl  = quad_io_enable_bit ? 1'b1 : dl_f_r[3];
  assign hold_fall = hold_d_r && !hold_lvl;
  assign hold_rise = !hold_d_r && hold_lvl;

  // Selection and arming. Arming needs select seen high from the pin
  // itself, not from the synchroniser's reset value, so a select held
  // low through reset never counts as a falling edge.
  logic [NS-1:0] flush_r;
  logic          cs_hi_seen_r;
  logic          armed_r;
  logic          sel;
  assign sel = !cs_f_r && armed_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flush_r      <= '0;
      cs_hi_seen_r <= 1'b0;
      armed_r      <= 1'b0;
    end else if (ce) begin
      flush_r <= {flush_r[NS-2:0], 1'b1};
      if (flush_r[NS-1] && cs_s_r[NS-1]) begin
        cs_hi_seen_r <= 1'b1;
      end
      if (cs_fall && cs_hi_seen_r) begin
        armed_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      standby_r <= 1'b0;
      active_r  <= 1'b0;
    end else if (ce) begin
      standby_r <= cs_f_r && !internal_busy;
      active_r  <= !cs_f_r;
    end
  end

  // Pause state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      paused_r <= 1'b0;
    end else if (ce) begin
      if (cs_f_r) begin
        paused_r <= 1'b0;
      end else if (sel && hold_fall && !sck_f_r) begin
        paused_r <= 1'b1;
      end else if (hold_rise && !sck_f_r) begin
        paused_r <= 1'b0;
      end
    end
  end

  // Effective lane count; quad only while enabled
  logic [1:0] lanes;
  always_comb begin
    lanes = 2'd0;
    case (lane_mode)
      flash_pin_pkg::LANES_2: lanes = 2'd1;
      flash_pin_pkg::LANES_4: lanes = quad_io_enable_bit ? 2'd2 : 2'd0;
      default:                lanes = 2'd0;
    endcase
  end

  // Receive shifter
  logic       shifting;
  logic [7:0] rx_sh_r;
  logic [2:0] bit_cnt_r;
  logic [1:0] byte_cnt_r;
  logic [7:0] rx_next;
  logic [2:0] bit_next;
  logic       byte_done;
  logic       buf_ready;

  assign shifting = sel && !paused_r && sck_rise && !return_data;
  always_comb begin
    rx_next  = {rx_sh_r[6:0], dl_f_r[0]};
    bit_next = bit_cnt_r + 3'd1;
    case (lanes)
      2'd1: begin
        rx_next  = {rx_sh_r[5:0], dl_f_r[1], dl_f_r[0]};
        bit_next = bit_cnt_r + 3'd2;
      end
      2'd2: begin
        rx_next  = {rx_sh_r[3:0], dl_f_r[3:0]};
        bit_next = bit_cnt_r + 3'd4;
      end
      default: begin
        rx_next  = {rx_sh_r[6:0], dl_f_r[0]};
        bit_next = bit_cnt_r + 3'd1;
      end
    endcase
  end
  assign byte_done = shifting && (bit_next == flash_pin_pkg::BIT_RST);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_sh_r    <= 8'h00;
      bit_cnt_r  <= flash_pin_pkg::BIT_RST;
      byte_cnt_r <= flash_pin_pkg::IDX_RST;
    end else if (ce) begin
      if (cs_f_r) begin
        bit_cnt_r  <= flash_pin_pkg::BIT_RST;
        byte_cnt_r <= flash_pin_pkg::IDX_RST;
      end else if (shifting) begin
        rx_sh_r   <= rx_next;
        bit_cnt_r <= bit_next;
        if (byte_done && byte_cnt_r != 2'd3) begin
          byte_cnt_r <= byte_cnt_r + 2'd1;
        end
      end
    end
  end

  // Bytes 1 to 3 of a selection form the byte address
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr_valid_r <= 1'b0;
      addr_info_r  <= '0;
    end else if (ce) begin
      if (cs_f_r) begin
        addr_valid_r <= 1'b0;
      end else if (byte_done && byte_cnt_r != 2'd0 && !addr_valid_r) begin
        addr_info_r.addr <= {addr_info_r.addr[15:0], rx_next};
        addr_valid_r     <= (byte_cnt_r == 2'd3);
      end else if (addr_valid_r) begin
        addr_info_r.sector     <= addr_info_r.addr[23:flash_pin_pkg::SECTOR_LSB];
        addr_info_r.half_block <= addr_info_r.addr[23:flash_pin_pkg::HALF_LSB];
        addr_info_r.block      <= addr_info_r.addr[23:flash_pin_pkg::BLOCK_LSB];
      end
    end
  end

  // The core cannot stall the host's clock, so a full buffer costs a
  // byte and raises a sticky overrun flag instead.
  flash_pin_pkg::rx_word_t push_word;
  assign push_word = '{data: rx_next, index: byte_cnt_r};
  rx_word_buffer #(
    .WIDTH ($bits(flash_pin_pkg::rx_word_t)),
    .DEPTH (flash_pin_pkg::BUF_DEPTH)
  ) u_rx_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (byte_done),
    .in_ready  (buf_ready),
    .in_data   (push_word),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_word)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_overrun_r <= 1'b0;
    end else if (ce && byte_done && !buf_ready) begin
      rx_overrun_r <= 1'b1;
    end
  end

  // Protect pin
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_write_blocked_r <= 1'b0;
    end else if (ce) begin
      status_write_blocked_r <= !quad_io_enable_bit && !status_protect_bit_hi
                                && status_protect_bit_lo && !dl_f_r[2];
    end
  end

  // Transmit shifter, loaded and advanced only on clock falls
  logic [7:0] tx_sh_r;
  logic [2:0] tx_left_r;
  logic       driving;
  logic [7:0] tx_src;
  assign driving = sel && !paused_r && return_data && sck_fall;
  assign tx_src  = (tx_left_r == 3'd0)
                   ? (tx_valid ? tx_data : flash_pin_pkg::TX_IDLE_BYTE)
                   : tx_sh_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_sh_r       <= 8'h00;
      tx_left_r     <= 3'd0;
      tx_take_r     <= 1'b0;
      data_line_out <= 4'h0;
    end else if (ce) begin
      tx_take_r <= driving && tx_left_r == 3'd0 && tx_valid;
      if (cs_f_r) begin
        tx_left_r <= 3'd0;
      end else if (driving) begin
        case (lanes)
          2'd1: begin
            data_line_out <= {2'b00, tx_src[7:6]};
            tx_sh_r       <= {tx_src[5:0], 2'b00};
            tx_left_r     <= tx_left_r - 3'd2;
          end
          2'd2: begin
            data_line_out <= tx_src[7:4];
            tx_sh_r       <= {tx_src[3:0], 4'h0};
            tx_left_r     <= tx_left_r - 3'd4;
          end
          default: begin
            data_line_out <= {2'b00, tx_src[7], 1'b0};
            tx_sh_r       <= {tx_src[6:0], 1'b0};
            tx_left_r     <= tx_left_r - 3'd1;
          end
        endcase
      end
    end
  end

  // Enables follow the lane width; off whenever deselected or paused
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_line_oe <= flash_pin_pkg::OE_OFF;
    end else if (ce) begin
      if (!sel || paused_r || !return_data) begin
        data_line_oe <= flash_pin_pkg::OE_OFF;
      end else if (driving) begin
        case (lanes)
          2'd1:    data_line_oe <= 4'h3;
          2'd2:    data_line_oe <= 4'hF;
          default: data_line_oe <= 4'h2;
        endcase
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_deselect_hiz;
    ce && cs_f_r |=> data_line_oe == 4'h0;
  endproperty
  a_deselect_hiz: assert property (p_deselect_hiz)
    else $error("enables on while deselected");

  property p_standby;
    ce ##1 ce |-> standby_r == $past(cs_f_r && !internal_busy);
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby flag wrong");

  property p_unarmed;
    !armed_r |-> bit_cnt_r == 3'd0 && !rx_valid;
  endproperty
  a_unarmed: assert property (p_unarmed)
    else $error("decoding before first select fall");

  property p_out_on_fall;
    ce && !(sck_d_r && !sck_f_r) |=> $stable(data_line_out);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall)
    else $error("output changed without clock fall");

  property p_sample_on_rise;
    ce && !cs_f_r && bit_cnt_r != $past(bit_cnt_r) |-> $past(shifting);
  endproperty
  a_sample_on_rise: assert property (p_sample_on_rise)
    else $error("bit sampled without clock rise");

  property p_protect;
    ce ##1 ce |-> status_write_blocked_r ==
      $past(!quad_io_enable_bit && !status_protect_bit_hi
            && status_protect_bit_lo && !dl_f_r[2]);
  endproperty
  a_protect: assert property (p_protect)
    else $error("protect block wrong");

  property p_pause_enter;
    ce && sel && hold_fall && !sck_f_r |=> paused_r;
  endproperty
  a_pause_enter: assert property (p_pause_enter)
    else $error("pause not entered");

  property p_pause_leave;
    ce && !cs_f_r && paused_r && hold_rise && !sck_f_r |=> !paused_r;
  endproperty
  a_pause_leave: assert property (p_pause_leave)
    else $error("pause not left");

  property p_pause_freeze;
    ce && paused_r && !cs_f_r |=> $stable(bit_cnt_r) && data_line_oe == 4'h0;
  endproperty
  a_pause_freeze: assert property (p_pause_freeze)
    else $error("state moved while paused");

  property p_quad_hold;
    quad_io_enable_bit && !paused_r && ce |=> !paused_r;
  endproperty
  a_quad_hold: assert property (p_quad_hold)
    else $error("paused with quad enabled");

  property p_cs_rise_clear;
    ce && cs_rise ##1 ce |=> bit_cnt_r == 3'd0 && byte_cnt_r == 2'd0
                             && !paused_r;
  endproperty
  a_cs_rise_clear: assert property (p_cs_rise_clear)
    else $error("partial bits kept after deselect");

  c_pause: cover property (ce && paused_r ##[1:50] !paused_r);
  c_byte: cover property (byte_done && byte_cnt_r == 2'd3);
  c_quad_tx: cover property (driving && lanes == 2'd2);
endmodule : serial_flash_pin_frontend
`default_nettype wire

/* host_spi_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_spi_model (
  // Clocking
  input  wire logic       sys_clk,
  // Link pins
  input  wire logic [3:0] lines,
  output logic            cs_n,
  output logic            sck,
  output logic [3:0]      out,
  output logic [3:0]      oe
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0; // Clock idles low between transfers
    out  = 4'h0;
    oe   = 4'h0;
  end

  // Half of the 200 ns link period
  task automatic half();
    repeat (4) @(negedge sys_clk);
  endtask : half

  // Lines are released on deselect so nothing stale stays on them
  task automatic sel(input logic on);
    @(negedge sys_clk);
    cs_n = ~on; // Low to select, high to deselect
    if (!on) oe = 4'h0;
    repeat (6) @(negedge sys_clk);
  endtask : sel

  // Pulls an upper pin low, only ever with the clock low
  task automatic pin_low(input int i, input logic on);
    @(negedge sys_clk);
    oe[i]  = on; // Pause only inside a selection
    out[i] = 1'b0;
    repeat (8) @(negedge sys_clk);
  endtask : pin_low

  // Data changes while the clock is low
  task automatic send(input logic [7:0] b, input int w, input int n);
    logic [7:0] s;
    s  = b;
    oe = oe | ((w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1);
    for (int g = 0; g < n; g++) begin
      case (w)
        4: out = s[7:4];
        2: out[1:0] = s[7:6];
        default: out[0] = s[7];
      endcase
      s = s << w;
      half();
      sck = 1'b1;
      half();
      sck = 1'b0;
    end
  endtask : send

  // Sampled late in the high phase: the device needs a few clocks to shift
  task automatic recv(input int w, output logic [7:0] b);
    b   = 8'h00;
    oe  = 4'h0; // Released so the device can drive
    sck = 1'b1;
    half();
    sck = 1'b0;
    for (int g = 0; g < 8 / w; g++) begin
      half();
      sck = 1'b1;
      half();
      case (w)
        4: b = {b[3:0], lines};
        2: b = {b[5:0], lines[1:0]};
        default: b = {b[6:0], lines[1]};
      endcase
      sck = 1'b0;
    end
  endtask : recv
endmodule : host_spi_model
`default_nettype wire

/* serial_flash_pin_frontend_test.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_flash_pin_frontend_test;
  logic                            sys_clk, rst, qe, sp_hi, sp_lo, busy;
  logic                            ret, rx_ready, rx_valid, tx_valid, take;
  logic                            stby, act, paused_r, blk, ovr, av;
  logic                            cs_n, sck, ce;
  logic [7:0]                      tx_data, got;
  logic [3:0]                      lvl, last, dl_out, dl_oe, h_out, h_oe;
  flash_pin_pkg::lane_mode_t       lane_mode;
  flash_pin_pkg::rx_word_t         rx_word;
  flash_pin_pkg::addr_info_t       ai;
  int                              n_fail, tests_run, cycles, n_take;

  serial_flash_pin_frontend serial_flash_pin_frontend_i (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .cs_n_pin(cs_n),
    .sck_pin(sck), .data_line_in(lvl), .data_line_out(dl_out),
    .data_line_oe(dl_oe), .quad_io_enable_bit(qe),
    .status_protect_bit_hi(sp_hi), .status_protect_bit_lo(sp_lo),
    .internal_busy(busy), .lane_mode(lane_mode), .return_data(ret),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word),
    .tx_valid(tx_valid), .tx_take_r(take), .tx_data(tx_data),
    .standby_r(stby), .active_r(act), .paused_r(paused_r),
    .status_write_blocked_r(blk), .rx_overrun_r(ovr),
    .addr_valid_r(av), .addr_info_r(ai));

  host_spi_model host_i (.sys_clk(sys_clk), .lines(lvl), .cs_n(cs_n),
    .sck(sck), .out(h_out), .oe(h_oe));

  // Undriven lines 0/1 toggle so a stale level cannot pass; 2/3 pull up
  always_comb begin
    for (int i = 0; i < 4; i++)
      lvl[i] = dl_oe[i] ? dl_out[i] : h_oe[i] ? h_out[i] :
               (i > 1) ? 1'b1 : ~last[i];
  end
  always @(negedge sys_clk) last <= lvl;

  // Bytes taken for return, one pulse each
  always @(posedge sys_clk) if (take === 1'b1) n_take++;

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [63:0] e,
                     input logic [63:0] s);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", what, e, s);
    end
  endtask : chk

  task automatic tx(input logic [7:0] b, input int w, input int n);
    @(negedge sys_clk);
    lane_mode = (w == 4) ? flash_pin_pkg::LANES_4 :
                (w == 2) ? flash_pin_pkg::LANES_2 : flash_pin_pkg::LANES_1;
    host_i.send(b, w, n);
  endtask : tx

  task automatic get_rx(input logic [7:0] d, input logic [1:0] idx);
    for (int n = 0; n < 200 && rx_valid !== 1'b1; n++) @(negedge sys_clk);
    chk("rx_word", {1'b1, d, idx}, {rx_valid, rx_word});
    rx_ready = 1'b1;
    @(negedge sys_clk);
    rx_ready = 1'b0;
    @(negedge sys_clk);
  endtask : get_rx

  task automatic t_arm();
    tx(8'h96, 1, 8);
    repeat (10) @(negedge sys_clk);
    chk("rx_valid", 0, rx_valid);
    host_i.sel(1'b0);
    host_i.sel(1'b1);
    chk("active_r", 1, act);
    tx(8'h3C, 1, 8);
    get_rx(8'h3C, 2'h0);
    host_i.sel(1'b0);
  endtask : t_arm

  task automatic t_standby();
    tx(8'h42, 1, 8);
    repeat (4) @(negedge sys_clk);
    chk("rx_valid", 0, rx_valid);
    chk("standby_r", 1, stby);
    busy = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("standby_r", 0, stby);
    busy = 1'b0;
    host_i.sel(1'b1);
    chk("stby act", 2'b01, {stby, act});
    host_i.sel(1'b0);
  endtask : t_standby

  task automatic t_partial();
    host_i.sel(1'b1);
    tx(8'hF0, 1, 4);
    host_i.sel(1'b0);
    host_i.sel(1'b1);
    tx(8'h5A, 1, 8);
    get_rx(8'h5A, 2'h0);
    lane_mode = flash_pin_pkg::LANES_4;
    host_i.send(8'hC9, 1, 8);
    get_rx(8'hC9, 2'h1);
    host_i.sel(1'b0);
  endtask : t_partial

  task automatic t_addr(input int w, input logic [23:0] a);
    host_i.sel(1'b1);
    tx(8'h0B, 1, 8);
    get_rx(8'h0B, 2'h0);
    for (int i = 0; i < 3; i++) begin
      tx(8'(a >> (16 - 8 * i)), w, 8 / w);
      get_rx(8'(a >> (16 - 8 * i)), 2'(i + 1));
    end
    tx(8'hE7, w, 8 / w);
    get_rx(8'hE7, 2'h3);
    chk("addr_info_r", {1'b1, a, a[23:12], a[23:15], a[23:16]}, {av, ai});
    host_i.sel(1'b0);
  endtask : t_addr

  task automatic t_pause();
    host_i.sel(1'b1);
    tx(8'hC3, 1, 4);
    host_i.pin_low(3, 1'b1);
    chk("paused_r", 1, paused_r);
    tx(8'hFF, 1, 4);
    host_i.pin_low(3, 1'b0);
    chk("paused_r", 0, paused_r);
    tx(8'h30, 1, 4);
    get_rx(8'hC3, 2'h0);
    host_i.pin_low(3, 1'b1);
    host_i.sel(1'b0);
    chk("paused_r", 0, paused_r);
    host_i.sel(1'b1);
    tx(8'h81, 1, 8);
    get_rx(8'h81, 2'h0);
    qe = 1'b1;
    host_i.pin_low(3, 1'b1);
    chk("paused_r", 0, paused_r);
    host_i.sel(1'b0);
    qe = 1'b0;
  endtask : t_pause

  // One byte back, plus the next one loaded on the closing clock fall
  task automatic t_read(input int w, input logic [3:0] e_oe,
                        input logic [7:0] d, input logic v);
    int         t0;
    logic [7:0] e;
    t0       = n_take;
    e        = v ? d : flash_pin_pkg::TX_IDLE_BYTE;
    tx_data  = d;
    tx_valid = v;
    host_i.sel(1'b1);
    tx(8'h00, w, 0);
    @(negedge sys_clk);
    ret = 1'b1;
    host_i.recv(w, got);
    chk("read byte", e, got);
    chk("data_line_oe", e_oe, dl_oe);
    host_i.sel(1'b0);
    ret = 1'b0;
    chk("data_line_oe", 0, dl_oe);
    chk("tx_take_r", v ? 2 : 0, n_take - t0);
  endtask : t_read

  task automatic t_protect();
    ce    = 1'b0;
    sp_lo = 1'b1;
    host_i.pin_low(2, 1'b1);
    chk("blocked frozen", 0, blk); // Clock enable low holds all state
    ce = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk("blocked", 1, blk);
    qe = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("blocked", 0, blk);
    qe    = 1'b0;
    sp_hi = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("blocked", 0, blk);
    sp_hi = 1'b0;
    host_i.pin_low(2, 1'b0);
    chk("blocked", 0, blk);
  endtask : t_protect

  // Receiver stalls: two words wait, the third is lost and flagged
  task automatic t_overrun();
    host_i.sel(1'b1);
    tx(8'h11, 1, 8);
    tx(8'h22, 1, 8);
    tx(8'h33, 1, 8);
    repeat (4) @(negedge sys_clk);
    chk("rx_overrun_r", 1, ovr);
    get_rx(8'h11, 2'h0);
    get_rx(8'h22, 2'h1);
    repeat (2) @(negedge sys_clk);
    chk("rx_valid", 0, rx_valid);
    host_i.sel(1'b0);
  endtask : t_overrun

  initial begin
    {rst, tx_valid} = 2'b11;
    ce = 1'b1;
    {qe, sp_hi, sp_lo, busy, ret, rx_ready} = 6'h00;
    tx_data   = 8'hA5;
    lane_mode = flash_pin_pkg::LANES_1;
    last      = 4'h0;
    host_i.sel(1'b1);
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_arm();
    t_standby();
    t_partial();
    t_addr(1, 24'h000FFF);
    t_addr(2, 24'hFE7123);
    qe = 1'b1;
    t_addr(4, 24'hFFFFFF);
    qe = 1'b0;
    t_pause();
    t_read(1, 4'h2, 8'hA5, 1'b1);
    t_read(1, 4'h2, 8'h00, 1'b0);
    t_read(2, 4'h3, 8'h3C, 1'b1);
    qe = 1'b1;
    t_read(4, 4'hF, 8'h96, 1'b1);
    qe = 1'b0;
    t_protect();
    t_overrun();
    stop_test();
  end
endmodule : serial_flash_pin_frontend_test
`default_nettype wire
